// [hdl/card_host_cfg.svh]
// timing constants and the rule summary for the card host handshake controller
// What this block does
// - dma ready low marks the receiver ready for ultra dma data-out bursts
// - host captures one word on each rising and each falling read strobe edge
// - memory mode: host write strobe writes data into card registers
// - ide mode: card ignores write strobe, host holds it high
// - mode select pin follows ide_mode_in directly; the internal mode is sampled only until card reset ends, then held
`ifndef CARD_HOST_CFG_SVH
`define CARD_HOST_CFG_SVH
`define CLK_PERIOD_NS      4
`define T_ADDR_SETUP_NS    30
`define T_WE_PULSE_NS      150
`define T_WE_RECOVERY_NS   30
`define T_OE_ACCESS_NS     150
`define T_RESET_NS         400
`define CYC_MIN(ns)        (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_IDE           1'b0
`define MODE_PCCARD        1'b1
`define CNT_W              8
`endif

// [hdl/card_host_pkg.sv]
// types shared by the card host controller
package card_host_pkg;
   typedef enum logic [2:0]
   {
      ST_RESET = 3'b000,
      ST_IDLE  = 3'b001,
      ST_SETUP = 3'b011,
      ST_PULSE = 3'b010,
      ST_WAIT  = 3'b110,
      ST_RECOV = 3'b111,
      ST_UDMA  = 3'b101
   } host_state_t;

   typedef struct packed
   {
      logic        write;
      logic        io;
      logic        attr;
      logic [10:0] addr;
      logic [15:0] wdata;
   } host_req_t;

   typedef struct packed
   {
      logic        word_port;
      logic        write_prot;
      logic [15:0] rdata;
   } host_rsp_t;
endpackage

// [hdl/udma_capture.sv]
// ultra dma read capture: one word on each strobe edge
`timescale 1ns/1ns
`default_nettype none
`include "card_host_cfg.svh"
module udma_capture
   import card_host_pkg::*;
#(
   parameter int DW = 16
)
(
   // clock and reset
   input  wire logic          mclk_in,
   input  wire logic          rst_in,
   // control
   input  wire logic          active_in,
   // link
   input  wire logic          strobe_in,
   input  wire logic [DW-1:0] data_in,
   // user side
   output logic               word_valid_out,
   output logic [DW-1:0]      word_out
);
   logic          strobe_q;
   logic          valid_q;
   logic [DW-1:0] word_q;
   wire           edge_seen = active_in && (strobe_in != strobe_q);

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         strobe_q <= 1'b0;
         valid_q  <= 1'b0;
         word_q   <= '0;
      end
      else
      begin
         // a still strobe is a pause and simply yields no words
         strobe_q <= strobe_in;
         valid_q  <= edge_seen;
         if (edge_seen)
            word_q <= data_in; // both edge directions count
      end
   end

   assign word_valid_out = valid_q;
   assign word_out       = word_q;
endmodule
`default_nettype wire

// [hdl/card_host.sv]
// host controller driving the card's handshake and strobe pins
`timescale 1ns/1ns
`default_nettype none
`include "card_host_cfg.svh"
module card_host
   import card_host_pkg::*;
#(
   parameter int SETUP_CYC = `CYC_MIN(`T_ADDR_SETUP_NS),
   parameter int PULSE_CYC = `CYC_MIN(`T_WE_PULSE_NS),
   parameter int RECOV_CYC = `CYC_MIN(`T_WE_RECOVERY_NS),
   parameter int RESET_CYC = `CYC_MIN(`T_RESET_NS)
)
(
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // user control
   input  wire logic        ide_mode_in,
   input  wire logic        req_valid_in,
   output logic             req_ready_out,
   input  wire host_req_t   req_in,
   output logic             rsp_valid_out,
   output host_rsp_t        rsp_out,
   input  wire logic        udma_read_in,
   input  wire logic        udma_write_in,
   input  wire logic        udma_pause_in,
   output logic             udma_word_valid_out,
   output logic [15:0]      udma_word_out,
   output logic             ready_seen_out,
   // card pins
   output logic             mode_sel_out,
   output logic             card_reset_out,
   output logic             ce_n_out,
   output logic             oe_n_out,
   output logic             we_n_out,
   output logic             iord_n_out,
   output logic             iowr_n_out,
   output logic             reg_n_out,
   output logic             dmack_n_out,
   output logic [10:0]      addr_out,
   output logic [15:0]      data_out,
   output logic             data_oe_out,
   input  wire logic [15:0] data_in,
   input  wire logic        wait_n_in,
   input  wire logic        dmardy_n_in,
   input  wire logic        dstrobe_in,
   input  wire logic        wp_in,
   input  wire logic        iois16_n_in,
   input  wire logic        iocs16_n_in
);
   host_state_t       state_q, state_d;
   logic [`CNT_W-1:0] cnt_q, cnt_d;
   host_req_t         req_q;
   logic              mode_q;
   logic              rsp_valid_q;
   host_rsp_t         rsp_q;
   logic              dmack_q;

   function automatic logic [`CNT_W-1:0] cyc(input int n);
      cyc = `CNT_W'(n - 1);
   endfunction

   // strobe is held low, not only while the card holds wait low
   wire cnt_done   = (cnt_q == '0);
   // wait low from the card stretches the pulse
   wire card_ready = wait_n_in;
   wire pulse_end  = cnt_done && card_ready;
   wire start      = (state_q == ST_IDLE) && req_valid_in;
   wire udma_go    = (state_q == ST_IDLE) && ide_mode_in && (udma_read_in || udma_write_in);
   wire strobe_on  = (state_q == ST_PULSE) || (state_q == ST_WAIT);
   // write strobe only outside ide mode; ide keeps it high
   wire we_active  = strobe_on && req_q.write && !req_q.io && (mode_q == `MODE_PCCARD);
   // 16-bit indication from the card per mode
   wire word_port  = (mode_q == `MODE_IDE) ? !iocs16_n_in : !iois16_n_in;

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_done ? cnt_q : cnt_q - `CNT_W'(1);
      case (state_q)
         ST_RESET:
            if (cnt_done)
               state_d = ST_IDLE;
         ST_IDLE:
            if (udma_go)
               state_d = ST_UDMA;
            else if (start)
            begin
               state_d = ST_SETUP;
               cnt_d   = cyc(SETUP_CYC);
            end
         ST_SETUP:
            if (cnt_done)
            begin
               state_d = ST_PULSE;
               cnt_d   = cyc(PULSE_CYC);
            end
         ST_PULSE:
            if (cnt_done)
               state_d = ST_WAIT;
         ST_WAIT:
            if (pulse_end)
            begin
               state_d = ST_RECOV;
               cnt_d   = cyc(RECOV_CYC);
            end
         ST_RECOV:
            if (cnt_done)
               state_d = ST_IDLE;
         ST_UDMA:
            if (!udma_read_in && !udma_write_in)
               state_d = ST_IDLE;
         default:
            state_d = ST_RESET;
      endcase
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         state_q <= ST_RESET;
         cnt_q   <= cyc(RESET_CYC);
         req_q   <= '0;
         dmack_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         if (start)
            req_q <= req_in;
         // acknowledge only while a dma burst runs
         dmack_q <= (state_d == ST_UDMA);
      end
   end

   // mode sampled from reset release until the card reset ends, then held
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
         mode_q <= `MODE_PCCARD;
      else if (state_q == ST_RESET)
         mode_q <= ide_mode_in ? `MODE_IDE : `MODE_PCCARD;
   end

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         rsp_valid_q <= 1'b0;
         rsp_q       <= '0;
      end
      else
      begin
         rsp_valid_q <= (state_q == ST_WAIT) && pulse_end;
         if ((state_q == ST_WAIT) && pulse_end)
         begin
            rsp_q.rdata      <= req_q.write ? rsp_q.rdata : data_in;
            rsp_q.word_port  <= word_port;
            // no switch on the card, so wp reads low after its reset
            rsp_q.write_prot <= (mode_q == `MODE_PCCARD) && wp_in;
         end
      end
   end

   udma_capture #(.DW(16)) u_capture
   (
      .mclk_in        (mclk_in),
      .rst_in         (rst_in),
      .active_in      ((state_q == ST_UDMA) && udma_read_in),
      .strobe_in      (dstrobe_in),
      .data_in        (data_in),
      .word_valid_out (udma_word_valid_out),
      .word_out       (udma_word_out)
   );

   assign req_ready_out  = (state_q == ST_IDLE) && !udma_go;
   assign rsp_valid_out  = rsp_valid_q;
   assign rsp_out        = rsp_q;
   // pin high picks memory or io, low picks ide
   assign mode_sel_out   = ide_mode_in ? `MODE_IDE : `MODE_PCCARD;
   assign card_reset_out = (state_q == ST_RESET);
   assign ce_n_out       = !((state_q == ST_SETUP) || strobe_on || (state_q == ST_RECOV));
   // memory write covers common and configuration registers
   assign we_n_out       = !we_active;
   assign oe_n_out       = !(strobe_on && !req_q.write && !req_q.io);
   assign iord_n_out     = !(strobe_on && !req_q.write && req_q.io);
   assign iowr_n_out     = !(strobe_on && req_q.write && req_q.io);
   assign reg_n_out      = !(req_q.attr || req_q.io);
   assign addr_out       = req_q.addr;
   assign data_out       = req_q.wdata;
   assign data_oe_out    = req_q.write && !ce_n_out;
   assign dmack_n_out    = !dmack_q;
   // host side readiness during ultra dma write, card pause mirrored
   assign ready_seen_out = (state_q == ST_UDMA) && udma_write_in && !dmardy_n_in
                           && !udma_pause_in;
endmodule
`default_nettype wire

// [tb/card_model.sv]
// behavioural card answering the host controller pins
`timescale 1ns/1ns
`default_nettype none
module card_model
(
   // host side
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ide_in,
   input  wire logic        ce_n_in,
   input  wire logic        rd_n_in,
   input  wire logic        wr_n_in,
   input  wire logic        io_n_in,
   input  wire logic        dmack_n_in,
   input  wire logic [10:0] addr_in,
   input  wire logic [15:0] data_in,
   // bench knobs
   input  wire logic [3:0]  stretch_in,
   input  wire logic        pause_in,
   // card answers
   output logic [15:0]      data_out,
   output logic             wait_n_out,
   output logic             dmardy_n_out,
   output logic             dstrobe_out,
   output logic             wp_out,
   output logic             iois16_n_out,
   output logic             iocs16_n_out
);
   logic [15:0] mem_q [16];
   logic [15:0] last_q;
   logic [7:0]  cnt_q;
   logic [3:0]  st_q;
   logic [1:0]  div_q;
   logic        act_q;
   logic        wr_q;
   wire         act = !rd_n_in || !wr_n_in;
   // acknowledge only counts while a burst runs
   wire         dma = ide_in && !dmack_n_in && !pause_in;
   assign wait_n_out = st_q == 4'h0;
   assign dmardy_n_out = !dma;
   assign dstrobe_out = cnt_q[0];
   assign iois16_n_out = io_n_in;
   assign iocs16_n_out = !(ide_in && !ce_n_in);
   // released bus toggles so stale data cannot pass
   assign data_out = !dmack_n_in ? {8'hA5, cnt_q} : !rd_n_in ? mem_q[addr_in[3:0]] : ~last_q;
   always_ff @(posedge mclk_in)
   begin
      act_q <= act && !rst_in;
      wr_q <= !wr_n_in && !rst_in;
      div_q <= rst_in ? 2'h0 : div_q + 2'h1;
      last_q <= data_out;
      wp_out <= rst_in;
      st_q <= rst_in ? 4'h0 : (act && !act_q) ? stretch_in : st_q - {3'h0, st_q != 4'h0};
      cnt_q <= rst_in ? 8'h00 : cnt_q + {7'h00, dma && div_q == 2'h3};
      if (wr_q && wr_n_in && !ide_in)
         mem_q[addr_in[3:0]] <= data_in;
   end
endmodule
`default_nettype wire

// [tb/card_host_props.sv]
// concurrent checks on the card host controller ports
`timescale 1ns/1ns
`default_nettype none
module card_host_props
   import card_host_pkg::*;
(
   input wire logic      mclk_in,
   input wire logic      rst_in,
   input wire logic      ide_mode_in,
   input wire logic      udma_read_in,
   input wire logic      udma_write_in,
   input wire logic      udma_pause_in,
   input wire logic      udma_word_valid_out,
   input wire logic      ready_seen_out,
   input wire logic      rsp_valid_out,
   input wire host_rsp_t rsp_out,
   input wire logic      oe_n_out,
   input wire logic      we_n_out,
   input wire logic      iord_n_out,
   input wire logic      iowr_n_out,
   input wire logic      dmack_n_out,
   input wire logic      wait_n_in,
   input wire logic      dmardy_n_in,
   input wire logic      dstrobe_in
);
   wire strobing = !(oe_n_out && we_n_out && iord_n_out && iowr_n_out);
   wire no_dma = !udma_read_in && !udma_write_in;
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_held;
      strobing && !wait_n_in;
   endsequence
   sequence s_quiet;
      $stable(dstrobe_in) [*4];
   endsequence
   sequence s_ready_ok;
      udma_write_in && !dmardy_n_in && !udma_pause_in && !dmack_n_out;
   endsequence
   sequence s_edge;
      udma_read_in && !dmack_n_out && $changed(dstrobe_in);
   endsequence
   a_wait_holds: assert property (s_held |=> strobing && !rsp_valid_out)
      else $error("cycle ended during wait");
   a_we_width: assert property ($fell(we_n_out) |-> !we_n_out [*3])
      else $error("write strobe too short");
   a_ide_no_we: assert property (ide_mode_in |-> we_n_out)
      else $error("write strobe in ide mode");
   a_wp_masked: assert property (rsp_valid_out && ide_mode_in |-> !rsp_out.write_prot)
      else $error("write protect set");
   a_ready_seen: assert property (ready_seen_out |-> s_ready_ok)
      else $error("ready seen while paused");
   a_edge_word: assert property (s_edge |-> ##[1:3] udma_word_valid_out)
      else $error("strobe edge lost");
   a_still_idle: assert property (s_quiet |=> !udma_word_valid_out)
      else $error("word without strobe edge");
   a_dmack_quiet: assert property (no_dma [*2] |-> dmack_n_out)
      else $error("acknowledge outside dma");
endmodule
bind card_host card_host_props u_props (.*);
`default_nettype wire

// [tb/tb_card_host.sv]
// self-checking bench for the card host handshake controller
`timescale 1ns/1ns
`default_nettype none
module tb_card_host;
   logic mclk_in = 0, rst_in = 1, ide_mode_in = 0, req_valid_in = 0, pause = 0;
   logic udma_read_in = 0, udma_write_in = 0, udma_pause_in = 0;
   logic [3:0] stretch = 0;
   card_host_pkg::host_req_t req_in = '0;
   card_host_pkg::host_rsp_t rsp_out;
   logic req_ready_out, rsp_valid_out, udma_word_valid_out, ready_seen_out, mode_sel_out;
   logic card_reset_out, ce_n_out, oe_n_out, we_n_out, iord_n_out, iowr_n_out, reg_n_out;
   logic dmack_n_out, data_oe_out, wait_n_in, dmardy_n_in, dstrobe_in, wp_in, iois16_n_in;
   logic iocs16_n_in;
   logic [15:0] udma_word_out, data_out, data_in;
   logic [10:0] addr_out;
   int n_fail = 0, num_checks = 0, cyc = 0, lat, n;
   card_host #(.SETUP_CYC(2), .PULSE_CYC(3), .RECOV_CYC(2), .RESET_CYC(4)) uut (.*);
   card_model cm (.mclk_in, .rst_in(card_reset_out), .ide_in(!mode_sel_out), .ce_n_in(ce_n_out),
      .rd_n_in(oe_n_out & iord_n_out), .wr_n_in(we_n_out & iowr_n_out),
      .io_n_in(iord_n_out & iowr_n_out), .dmack_n_in(dmack_n_out), .addr_in(addr_out),
      .data_in(data_out), .stretch_in(stretch), .pause_in(pause), .data_out(data_in),
      .wait_n_out(wait_n_in), .dmardy_n_out(dmardy_n_in), .dstrobe_out(dstrobe_in),
      .wp_out(wp_in), .iois16_n_out(iois16_n_in), .iocs16_n_out(iocs16_n_in));
   initial forever #2 mclk_in = ~mclk_in;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         results();
      end
   end
   // mode only changes under reset
   task automatic do_reset(input logic ide);
      ide_mode_in <= ide;
      rst_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rst_in <= 1'b0;
      do @(posedge mclk_in); while (!req_ready_out);
      check(mode_sel_out, !ide);
   endtask
   task automatic access(input logic w, io, at, input logic [10:0] a, input logic [15:0] d);
      req_in <= '{w, io, at, a, d};
      req_valid_in <= 1'b1;
      do @(posedge mclk_in); while (!req_ready_out);
      req_valid_in <= 1'b0;
      @(posedge mclk_in);
      check(reg_n_out, !(at || io));
      check(data_oe_out, w);
      lat = 1;
      do @(posedge mclk_in); while (!rsp_valid_out && ++lat < 200);
      check(lat < 200, 1'b1);
   endtask
   task automatic t_pccard();
      for (int i = 0; i < 4; i++)
      begin
         access(1'b1, i[0], i[1], 11'(i + 1), 16'hC3A0 + 16'(i));
         access(1'b0, i[0], i[1], 11'(i + 1), 16'h0000);
         check(rsp_out.rdata, 16'hC3A0 + 16'(i));
         check(rsp_out.write_prot, 1'b0);
         check(rsp_out.word_port, i[0]);
         check(lat inside {[6:7]}, 1'b1);
      end
      stretch <= 4'h8;
      access(1'b0, 1'b0, 1'b0, 11'h001, 16'h0000);
      check(lat >= 11, 1'b1);
      stretch <= 4'h0;
      $display("pc card test done");
   endtask
   task automatic t_ide();
      do_reset(1'b1);
      access(1'b1, 1'b0, 1'b0, 11'h002, 16'h5A5A);
      access(1'b0, 1'b0, 1'b0, 11'h002, 16'h0000);
      check(rsp_out.rdata, 16'hC3A1);
      check(rsp_out.word_port, 1'b1);
      check(rsp_out.write_prot, 1'b0);
      udma_read_in <= 1'b1;
      n = 0;
      repeat (60)
      begin
         @(posedge mclk_in);
         if (udma_word_valid_out === 1'b1)
         begin
            n++;
            check(udma_word_out, {8'hA5, 8'(n)});
         end
      end
      check(n >= 12, 1'b1);
      pause <= 1'b1;
      repeat (6) @(posedge mclk_in);
      n = 0;
      repeat (20)
      begin
         @(posedge mclk_in);
         n += int'(udma_word_valid_out === 1'b1);
      end
      check(n, 0);
      pause <= 1'b0;
      udma_read_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      udma_write_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
      check(ready_seen_out, 1'b1);
      pause <= 1'b1;
      repeat (2) @(posedge mclk_in);
      check(ready_seen_out, 1'b0);
      pause <= 1'b0;
      udma_pause_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      check(ready_seen_out, 1'b0);
      udma_pause_in <= 1'b0;
      udma_write_in <= 1'b0;
      $display("ide test done");
   endtask
   initial
   begin
      do_reset(1'b0);
      t_pccard();
      t_ide();
      results();
   end
endmodule
`default_nettype wire
